//--- core/wdtsys_pkg.sv
// Overview of operation
// R1: Two independent windowed watchdogs, each with an optional window mode.
// R2: Each windowed watchdog has a prescaled 32-bit counter; expiry resets.
// R3: Software must service enabled windowed watchdogs in time, inside window.
// R4: A service outside the programmed window is a failure and causes timeout.
// R5: A windowed watchdog expiry sets its own cause flag, kept across reset.
// R6: Windowed count clock selects scaled system clock, RTC or power clock.
// R7: Recovery watchdog has a 16-bit counter; expiry requests system reset.
// R8: Software services enabled recovery watchdog in time; it has no window.
// R9: Recovery expiry sets a dedicated cause flag readable after reset.
// R10: Recovery watchdog counts only on the 8 kHz ring oscillator.
// R11: A valid service reloads the counter and restarts period and window.
package wdtsys_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_A_CTRL    = 8'h00;
  localparam logic [7:0] OFF_A_TIMEOUT = 8'h04;
  localparam logic [7:0] OFF_A_WINDOW  = 8'h08;
  localparam logic [7:0] OFF_A_SERVICE = 8'h0c;
  localparam logic [7:0] OFF_A_COUNT   = 8'h10;
  localparam logic [7:0] OFF_B_CTRL    = 8'h20;
  localparam logic [7:0] OFF_B_TIMEOUT = 8'h24;
  localparam logic [7:0] OFF_B_WINDOW  = 8'h28;
  localparam logic [7:0] OFF_B_SERVICE = 8'h2c;
  localparam logic [7:0] OFF_B_COUNT   = 8'h30;
  localparam logic [7:0] OFF_R_CTRL    = 8'h40;
  localparam logic [7:0] OFF_R_TIMEOUT = 8'h44;
  localparam logic [7:0] OFF_R_SERVICE = 8'h48;
  localparam logic [7:0] OFF_R_COUNT   = 8'h4c;
  localparam logic [7:0] OFF_CAUSE     = 8'h50;
  localparam logic [7:0] OFF_STATUS    = 8'h54;

  // Control field positions
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_WIN_BIT = 1;
  localparam int CTRL_SRC_LSB = 2;
  localparam int CTRL_PRE_LSB = 4;
  localparam int CTRL_W       = 8;

  // Cause and status bit positions
  localparam int CAUSE_A_BIT = 0;
  localparam int CAUSE_B_BIT = 1;
  localparam int CAUSE_R_BIT = 2;

  // Values after reset
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [31:0] TIMEOUT_RST     = 32'hffff_ffff;
  localparam logic [31:0] WINDOW_RST      = 32'h0000_0000;
  localparam logic [15:0] REC_TIMEOUT_RST = 16'hffff;

  // Reference clock cycles per scaled system clock tick
  localparam int SCALE_DIV_DEF = 25;

  typedef enum logic [1:0] {
    SRC_SYS  = 2'h0,
    SRC_RTC  = 2'h1,
    SRC_PM   = 2'h2,
    SRC_NONE = 2'h3
  } wdtsys_clk_src_t;

  typedef enum logic [2:0] {
    WST_IDLE = 3'h1,
    WST_RUN  = 3'h2,
    WST_EXP  = 3'h4
  } wdtsys_wd_state_t;

endpackage : wdtsys_pkg

//--- core/wdtsys_window.sv
`timescale 1ns/1ps
module wdtsys_window #(
  parameter int CNT_W = 32,
  parameter int PRE_W = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             tick,
  input  wire logic             enable,
  input  wire logic             window_en,
  input  wire logic [3:0]       presc_sel,
  input  wire logic [CNT_W-1:0] timeout_val,
  input  wire logic [CNT_W-1:0] window_val,
  input  wire logic             service,
  output logic      [CNT_W-1:0] count,
  output logic                  running,
  output logic                  expired
);
  import wdtsys_pkg::*;

  if (PRE_W < 16 || CNT_W < 2) begin : g_chk
    $error("wdtsys_window: prescaler needs 16 bits, counter 2");
  end

  wdtsys_wd_state_t state;
  logic [PRE_W-1:0] pre_cnt;
  logic             cnt_tick;
  logic             early;
  logic             svc_ok;
  logic             svc_fail;
  logic             over;

  function automatic logic [PRE_W-1:0] presc_limit(input logic [3:0] sel);
    presc_limit = PRE_W'((32'h1 << sel) - 32'h1);
  endfunction : presc_limit

  assign running  = (state == WST_RUN);
  assign cnt_tick = tick && (pre_cnt == presc_limit(presc_sel));
  assign early    = window_en && (count < window_val); // R4
  assign svc_ok   = running && service && !early; // R11
  assign svc_fail = running && service && early; // R4
  assign over     = running && !service && cnt_tick
                    && (count >= timeout_val); // R2

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= WST_IDLE;
    end else begin
      unique case (state)
        WST_IDLE: begin
          if (enable) begin
            state <= WST_RUN;
          end
        end
        WST_RUN: begin
          if (!enable) begin
            state <= WST_IDLE;
          end else if (svc_fail || over) begin
            state <= WST_EXP;
          end
        end
        WST_EXP: begin
          if (!enable) begin
            state <= WST_IDLE;
          end
        end
        default: begin
          state <= WST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler restarts with every reload
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !running || svc_ok) begin
      pre_cnt <= '0; // R11
    end else if (tick) begin
      pre_cnt <= cnt_tick ? '0 : pre_cnt + PRE_W'(1); // R2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || state == WST_IDLE) begin
      count <= '0;
    end else if (svc_ok) begin
      count <= '0; // R11
    end else if (running && cnt_tick && !over) begin
      count <= count + CNT_W'(1); // R2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      expired <= 1'b0;
    end else begin
      expired <= svc_fail || over; // R4
    end
  end

endmodule : wdtsys_window

//--- core/wdtsys_recovery.sv
`timescale 1ns/1ps
module wdtsys_recovery #(
  parameter int CNT_W = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             ring_tick,
  input  wire logic             enable,
  input  wire logic [CNT_W-1:0] timeout_val,
  input  wire logic             service,
  output logic      [CNT_W-1:0] count,
  output logic                  running,
  output logic                  expired
);
  import wdtsys_pkg::*;

  if (CNT_W < 2) begin : g_chk
    $error("wdtsys_recovery: counter needs at least 2 bits");
  end

  wdtsys_wd_state_t state;
  logic             over;

  assign running = (state == WST_RUN);
  assign over    = running && !service && ring_tick
                   && (count >= timeout_val); // R7

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= WST_IDLE;
    end else begin
      unique case (state)
        WST_IDLE: begin
          if (enable) begin
            state <= WST_RUN;
          end
        end
        WST_RUN: begin
          if (!enable) begin
            state <= WST_IDLE;
          end else if (over) begin
            state <= WST_EXP;
          end
        end
        WST_EXP: begin
          if (!enable) begin
            state <= WST_IDLE;
          end
        end
        default: begin
          state <= WST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || state == WST_IDLE) begin
      count <= '0;
    end else if (running && service) begin
      count <= '0; // R11
    end else if (running && ring_tick && !over) begin
      count <= count + CNT_W'(1); // R10
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      expired <= 1'b0;
    end else begin
      expired <= over; // R7
    end
  end

endmodule : wdtsys_recovery

//--- core/wdtsys_top.sv
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module wdtsys_top #(
  parameter int SCALE_DIV = wdtsys_pkg::SCALE_DIV_DEF
) (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        por_rst,
  input  wire logic                        rtc_clk_in,
  input  wire logic                        pm_clk_in,
  input  wire logic                        ring_osc_in,
  input  wire logic [wdtsys_pkg::ADDR_W-1:0] addr,
  input  wire logic [wdtsys_pkg::DATA_W-1:0] wr_data,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [wdtsys_pkg::DATA_W-1:0] rd_data,
  output logic                             sys_reset_req,
  output logic      [2:0]                  reset_cause
);
  import wdtsys_pkg::*;

  if (SCALE_DIV < 1) begin : g_chk
    $error("wdtsys_top: SCALE_DIV must be at least 1");
  end

  localparam int DIV_W = (SCALE_DIV > 1) ? $clog2(SCALE_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCALE_DIV - 1);

  logic             rst;
  logic [2:0]       sync1;
  logic [2:0]       sync2;
  logic [2:0]       sync3;
  logic             rtc_tick;
  logic             pm_tick;
  logic             ring_tick;
  logic [DIV_W-1:0] div_cnt;
  logic             sys_tick;

  logic [CTRL_W-1:0] a_ctrl;
  logic [31:0]       a_timeout;
  logic [31:0]       a_window;
  logic [CTRL_W-1:0] b_ctrl;
  logic [31:0]       b_timeout;
  logic [31:0]       b_window;
  logic              r_enable;
  logic [15:0]       r_timeout;
  logic [2:0]        cause;

  logic        a_service;
  logic        b_service;
  logic        r_service;
  logic        a_tick;
  logic        b_tick;
  logic [31:0] a_count;
  logic [31:0] b_count;
  logic [15:0] r_count;
  logic        a_running;
  logic        b_running;
  logic        r_running;
  logic        a_expired;
  logic        b_expired;
  logic        r_expired;
  logic [2:0]  cause_set;
  logic [2:0]  cause_clr;
  logic [DATA_W-1:0] next_rd_data;

  // Watchdog logic restarts on either reset; cause flags only on power-on
  assign rst = sys_rst || por_rst;

  function automatic logic sel_tick(input logic [1:0] sel,
                                    input logic       t_sys,
                                    input logic       t_rtc,
                                    input logic       t_pm);
    unique case (wdtsys_clk_src_t'(sel))
      SRC_SYS:  sel_tick = t_sys;
      SRC_RTC:  sel_tick = t_rtc;
      SRC_PM:   sel_tick = t_pm;
      SRC_NONE: sel_tick = 1'b0;
    endcase
  endfunction : sel_tick

  function automatic logic wr_hit(input logic                    en,
                                  input logic [ADDR_W-1:0]       a,
                                  input logic [7:0]              off);
    wr_hit = en && (a == off);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Clock source synchronisers and rising edge ticks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end else begin
      sync1 <= {ring_osc_in, pm_clk_in, rtc_clk_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign rtc_tick  = sync2[0] && !sync3[0];
  assign pm_tick   = sync2[1] && !sync3[1];
  assign ring_tick = sync2[2] && !sync3[2]; // R10

  // Scaled system clock as an enable pulse
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt <= '0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  assign sys_tick = (div_cnt == DIV_LAST);

  assign a_tick = sel_tick(a_ctrl[CTRL_SRC_LSB +: 2],
                           sys_tick, rtc_tick, pm_tick); // R6
  assign b_tick = sel_tick(b_ctrl[CTRL_SRC_LSB +: 2],
                           sys_tick, rtc_tick, pm_tick); // R6

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      a_ctrl    <= CTRL_RST;
      a_timeout <= TIMEOUT_RST;
      a_window  <= WINDOW_RST;
    end else begin
      if (wr_hit(wr_en, addr, OFF_A_CTRL)) begin
        a_ctrl <= wr_data[CTRL_W-1:0];
      end
      if (wr_hit(wr_en, addr, OFF_A_TIMEOUT)) begin
        a_timeout <= wr_data;
      end
      if (wr_hit(wr_en, addr, OFF_A_WINDOW)) begin
        a_window <= wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      b_ctrl    <= CTRL_RST;
      b_timeout <= TIMEOUT_RST;
      b_window  <= WINDOW_RST;
    end else begin
      if (wr_hit(wr_en, addr, OFF_B_CTRL)) begin
        b_ctrl <= wr_data[CTRL_W-1:0];
      end
      if (wr_hit(wr_en, addr, OFF_B_TIMEOUT)) begin
        b_timeout <= wr_data;
      end
      if (wr_hit(wr_en, addr, OFF_B_WINDOW)) begin
        b_window <= wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_enable  <= 1'b0;
      r_timeout <= REC_TIMEOUT_RST;
    end else begin
      if (wr_hit(wr_en, addr, OFF_R_CTRL)) begin
        r_enable <= wr_data[CTRL_EN_BIT];
      end
      if (wr_hit(wr_en, addr, OFF_R_TIMEOUT)) begin
        r_timeout <= wr_data[15:0];
      end
    end
  end

  assign a_service = wr_hit(wr_en, addr, OFF_A_SERVICE);
  assign b_service = wr_hit(wr_en, addr, OFF_B_SERVICE);
  assign r_service = wr_hit(wr_en, addr, OFF_R_SERVICE);

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog instances
  wdtsys_window #(
    .CNT_W (32),
    .PRE_W (16)
  ) u_windowed_watchdog_a (
    .ref_clk     (ref_clk),
    .sys_rst     (rst),
    .tick        (a_tick),
    .enable      (a_ctrl[CTRL_EN_BIT]),
    .window_en   (a_ctrl[CTRL_WIN_BIT]),
    .presc_sel   (a_ctrl[CTRL_PRE_LSB +: 4]),
    .timeout_val (a_timeout),
    .window_val  (a_window),
    .service     (a_service),
    .count       (a_count),
    .running     (a_running),
    .expired     (a_expired)
  ); // R1

  wdtsys_window #(
    .CNT_W (32),
    .PRE_W (16)
  ) u_windowed_watchdog_b (
    .ref_clk     (ref_clk),
    .sys_rst     (rst),
    .tick        (b_tick),
    .enable      (b_ctrl[CTRL_EN_BIT]),
    .window_en   (b_ctrl[CTRL_WIN_BIT]),
    .presc_sel   (b_ctrl[CTRL_PRE_LSB +: 4]),
    .timeout_val (b_timeout),
    .window_val  (b_window),
    .service     (b_service),
    .count       (b_count),
    .running     (b_running),
    .expired     (b_expired)
  ); // R1

  wdtsys_recovery #(
    .CNT_W (16)
  ) u_recovery_watchdog (
    .ref_clk     (ref_clk),
    .sys_rst     (rst),
    .ring_tick   (ring_tick),
    .enable      (r_enable),
    .timeout_val (r_timeout),
    .service     (r_service),
    .count       (r_count),
    .running     (r_running),
    .expired     (r_expired)
  ); // R7

  ////////////////////////////////////////////////////////////////////////////
  // Reset request and cause flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= a_expired || b_expired || r_expired; // R2
    end
  end

  assign cause_set = {r_expired, b_expired, a_expired};
  assign cause_clr = wr_hit(wr_en, addr, OFF_CAUSE) ? wr_data[2:0] : 3'h0;

  // Survives sys_rst so software can read why the system restarted
  always_ff @(posedge ref_clk) begin
    if (por_rst) begin
      cause <= 3'h0;
    end else begin
      cause <= cause_set | (cause & ~cause_clr); // R5 R9
    end
  end

  always_ff @(posedge ref_clk) begin
    if (por_rst) begin
      reset_cause <= 3'h0;
    end else begin
      reset_cause <= cause_set | (cause & ~cause_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always_comb begin
    next_rd_data = '0;
    unique case (addr)
      OFF_A_CTRL:    next_rd_data = {24'h0, a_ctrl};
      OFF_A_TIMEOUT: next_rd_data = a_timeout;
      OFF_A_WINDOW:  next_rd_data = a_window;
      OFF_A_COUNT:   next_rd_data = a_count;
      OFF_B_CTRL:    next_rd_data = {24'h0, b_ctrl};
      OFF_B_TIMEOUT: next_rd_data = b_timeout;
      OFF_B_WINDOW:  next_rd_data = b_window;
      OFF_B_COUNT:   next_rd_data = b_count;
      OFF_R_CTRL:    next_rd_data = {31'h0, r_enable};
      OFF_R_TIMEOUT: next_rd_data = {16'h0, r_timeout};
      OFF_R_COUNT:   next_rd_data = {16'h0, r_count};
      OFF_CAUSE:     next_rd_data = {29'h0, cause};
      OFF_STATUS:    next_rd_data = {29'h0, r_running, b_running, a_running};
      default:       next_rd_data = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= next_rd_data;
    end else begin
      rd_data <= '0;
    end
  end

endmodule : wdtsys_top

//--- bench/wdtsys_top_sva.sv
`timescale 1ns/1ps
module wdtsys_top_sva
  import wdtsys_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire logic              por_rst,
  input wire logic              rtc_clk_in,
  input wire logic              pm_clk_in,
  input wire logic              ring_osc_in,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              sys_reset_req,
  input wire logic [2:0]        reset_cause
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst || por_rst);

  sequence rd_at(logic [7:0] a);
    rd_en && addr == a;
  endsequence

  sequence cause_wr;
    wr_en && addr == OFF_CAUSE;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  req_pulse_a: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request longer than one cycle");
  quiet_start_a: assert property ($fell(sys_rst) |-> !sys_reset_req [*3])
    else $error("reset request right after reset");
  cause_rise_a: assert property (
    |(reset_cause & ~$past(reset_cause)) |-> sys_reset_req)
    else $error("cause flag set without reset request");
  req_cause_a: assert property (sys_reset_req |-> reset_cause != 3'h0)
    else $error("reset request without cause flag");
  cause_keep_a: assert property (@(posedge ref_clk) disable iff (por_rst)
    |($past(reset_cause) & ~reset_cause) |->
      $past(por_rst) || $past(wr_en && addr == OFF_CAUSE)
      || $past(wr_en && addr == OFF_CAUSE, 2))
    else $error("cause flag lost without clear");
  cause_read_a: assert property (
    rd_at(OFF_CAUSE) |=> rd_data == {29'h0, $past(reset_cause)})
    else $error("cause register read differs from cause output");
  svc_read_a: assert property (rd_at(OFF_A_SERVICE) |=> rd_data == 32'h0)
    else $error("service register reads nonzero");
  rec_width_a: assert property (
    rd_at(OFF_R_TIMEOUT) |=> rd_data[31:16] == 16'h0)
    else $error("recovery timeout wider than 16 bits");
  rec_ctrl_a: assert property (
    rd_at(OFF_R_CTRL) |=> rd_data[31:1] == 31'h0)
    else $error("recovery control has extra bits");
  status_w_a: assert property (
    rd_at(OFF_STATUS) |=> rd_data[31:3] == 29'h0)
    else $error("status upper bits nonzero");
  cover property (cause_wr ##1 1);
endmodule : wdtsys_top_sva

bind wdtsys_top wdtsys_top_sva i_wdtsys_top_sva (
  .ref_clk, .sys_rst, .por_rst, .rtc_clk_in, .pm_clk_in, .ring_osc_in,
  .addr, .wr_data, .wr_en, .rd_en, .rd_data, .sys_reset_req, .reset_cause
);

//--- bench/wdtsys_bench.sv
`timescale 1ns/1ps
module wdtsys_bench;
  import wdtsys_pkg::*;
  localparam int DIV = 2;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        por_rst = 1'b1;
  logic        rtc_clk_in = 1'b0;
  logic        pm_clk_in = 1'b0;
  logic        ring_osc_in = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [31:0] rd_data;
  logic        sys_reset_req;
  logic [2:0]  reset_cause;
  logic [2:0]  exp_cause = 3'h0;
  logic [31:0] seed = 32'h5e85;
  logic [31:0] v;
  logic [31:0] mdl [int];
  logic [7:0]  q [$];
  int          errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          req_seen = 0;
  int          n;
  int          t;
  int          k;

  always #20 ref_clk = ~ref_clk;

  // Slow source clocks, all divided from cyc: periods of 6, 8 and 10 ref_clk cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    rtc_clk_in <= (cyc % 6) < 3;
    pm_clk_in <= (cyc % 8) < 4;
    ring_osc_in <= (cyc % 10) < 5;
    if (sys_reset_req === 1'b1) req_seen <= req_seen + 1;
  end

  wdtsys_top #(.SCALE_DIV(DIV)) i_wdtsys_top (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .por_rst(por_rst),
    .rtc_clk_in(rtc_clk_in), .pm_clk_in(pm_clk_in),
    .ring_osc_in(ring_osc_in), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .sys_reset_req(sys_reset_req), .reset_cause(reset_cause)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    chk(rd_data, exp);
  endtask : rd_chk

  task automatic wait_req(input int lim);
    n = 0;
    while (sys_reset_req !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_req

  task automatic rst_sys();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask : rst_sys

  task automatic test_done();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  initial begin
    #(40 * 8000);
    errors++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    q = '{OFF_A_TIMEOUT, OFF_A_WINDOW, OFF_B_TIMEOUT, OFF_B_WINDOW,
          OFF_R_TIMEOUT, OFF_A_SERVICE, OFF_A_COUNT, OFF_STATUS, 8'hfc};
    foreach (q[i]) mdl[q[i]] = 32'h0;
    mdl[OFF_A_TIMEOUT] = TIMEOUT_RST;
    mdl[OFF_B_TIMEOUT] = TIMEOUT_RST;
    mdl[OFF_R_TIMEOUT] = 32'(REC_TIMEOUT_RST);
    foreach (q[i]) rd_chk(q[i], mdl[q[i]]);
    foreach (q[i]) begin
      seed = lfsr(seed);
      wr(q[i], seed);
      if (i < 4) mdl[q[i]] = seed;
      if (i == 4) mdl[q[i]] = seed & 32'hffff;
    end
    foreach (q[i]) rd_chk(q[i], mdl[q[i]]);
    $display("test registers done");

    for (k = 0; k < 3; k++) begin
      rst_sys();
      t = DIV << k;
      wr(OFF_A_TIMEOUT, 32'h2);
      wr(OFF_A_CTRL, 32'((k << 4) | 1));
      wait_req(200);
      chk(32'(n >= 2 * t && n <= 3 * t + 6), 32'h1);
      exp_cause[0] = 1'b1;
      chk(32'(reset_cause), 32'(exp_cause));
    end
    rst_sys();
    rd_chk(OFF_CAUSE, 32'(exp_cause));
    wr(OFF_CAUSE, 32'h7);
    exp_cause = 3'h0;
    rd_chk(OFF_CAUSE, 32'h0);
    $display("test prescaler done");

    for (k = 0; k < 4; k++) begin
      rst_sys();
      wr(OFF_B_TIMEOUT, 32'h1);
      wr(OFF_B_CTRL, 32'((k << 2) | 1));
      wait_req(100);
      chk(32'(sys_reset_req), 32'(k != 3));
      if (k != 3) exp_cause[1] = 1'b1;
      chk(32'(reset_cause), 32'(exp_cause));
      if (k == 3) rd_chk(OFF_STATUS, 32'h2);
    end
    $display("test sources done");

    rst_sys();
    wr(OFF_A_TIMEOUT, 32'h3);
    wr(OFF_A_CTRL, 32'h1);
    t = req_seen;
    repeat (10) begin
      repeat (2 * DIV) @(posedge ref_clk);
      seed = lfsr(seed);
      wr(OFF_A_SERVICE, seed);
    end
    chk(32'(req_seen), 32'(t));
    wait_req(40);
    chk(32'(sys_reset_req), 32'h1);
    exp_cause[0] = 1'b1;
    chk(32'(reset_cause), 32'(exp_cause));
    $display("test service done");

    rst_sys();
    wr(OFF_A_TIMEOUT, 32'h14);
    wr(OFF_A_WINDOW, 32'h5);
    wr(OFF_A_CTRL, 32'h3);
    wr(OFF_A_SERVICE, 32'h0);
    wait_req(6);
    chk(32'(sys_reset_req), 32'h1);
    rst_sys();
    wr(OFF_A_TIMEOUT, 32'h14);
    wr(OFF_A_WINDOW, 32'h5);
    wr(OFF_A_CTRL, 32'h3);
    repeat (8 * DIV) @(posedge ref_clk);
    t = req_seen;
    wr(OFF_A_SERVICE, 32'h0);
    repeat (6) @(posedge ref_clk);
    chk(32'(req_seen), 32'(t));
    rd_chk(OFF_STATUS, 32'h1);
    $display("test window done");

    rst_sys();
    wr(OFF_R_TIMEOUT, 32'h1);
    wr(OFF_R_CTRL, 32'h1);
    t = req_seen;
    repeat (5) begin
      repeat (4) @(posedge ref_clk);
      seed = lfsr(seed);
      wr(OFF_R_SERVICE, seed);
    end
    chk(32'(req_seen), 32'(t));
    wait_req(80);
    chk(32'(sys_reset_req), 32'h1);
    exp_cause[2] = 1'b1;
    chk(32'(reset_cause), 32'(exp_cause));
    @(posedge ref_clk);
    por_rst <= 1'b1;
    @(posedge ref_clk);
    por_rst <= 1'b0;
    rd_chk(OFF_CAUSE, 32'h0);
    $display("test recovery done");
    test_done();
  end
endmodule : wdtsys_bench
